// ### common/pwc_regs.svh
/*
 * register indices, field layouts, reset values and timing for the pll
 * supervisor and audio clock generator configuration block.
 * assumes: included by bare name; byte address is four times the index.
 */
`ifndef PWC_REGS_SVH
`define PWC_REGS_SVH

// ----------------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------------
`define PWC_IDX_SUP_CTRL 16'hf006
`define PWC_IDX_G1_DENOM 16'hf020
`define PWC_IDX_G1_NUMER 16'hf021
`define PWC_IDX_G2_DENOM 16'hf022
`define PWC_IDX_G2_NUMER 16'hf023
`define PWC_IDX_G3_DENOM 16'hf024
`define PWC_IDX_G3_NUMER 16'hf025
`define PWC_IDX_G3_SRC 16'hf026
`define PWC_IDX_SUP_STAT 16'hf030

// ----------------------------------------------------------------------
// bus geometry and fields
// ----------------------------------------------------------------------
`define PWC_ADDR_W 18
`define PWC_FRAC_W 9
`define PWC_SUP_EN_BIT 0
`define PWC_SRC_EXT_BIT 4
`define PWC_SRC_PIN_HI 3
`define PWC_SRC_PIN_LO 0
`define PWC_EXT_DIVISOR 16'h0400

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define PWC_RST_SUP_CTRL 1'h1
`define PWC_RST_G1_DENOM 9'h006
`define PWC_RST_G1_NUMER 9'h001
`define PWC_RST_G2_DENOM 9'h009
`define PWC_RST_G2_NUMER 9'h001
`define PWC_RST_G3_DENOM 16'h0000
`define PWC_RST_G3_NUMER 16'h0000
`define PWC_RST_G3_EXT 1'h0
`define PWC_RST_G3_PIN 4'he

// ----------------------------------------------------------------------
// reference pin codes
// ----------------------------------------------------------------------
`define PWC_PIN_MP0 4'h0
`define PWC_PIN_MP1 4'h1
`define PWC_PIN_MP2 4'h2
`define PWC_PIN_MP3 4'h3
`define PWC_PIN_FRM0 4'h4
`define PWC_PIN_FRM1 4'h5
`define PWC_PIN_SPDIF 4'he

// ----------------------------------------------------------------------
// timing: pll reset hold, 1000 ns at 50 ns clock period
// ----------------------------------------------------------------------
`define PWC_CLK_NS 50
`define PWC_PLL_RST_NS 1000
`define PWC_PLL_RST_CYC ((`PWC_PLL_RST_NS + `PWC_CLK_NS - 1) / `PWC_CLK_NS)
`define PWC_AXI_OKAY 2'h0
`define PWC_AXI_SLVERR 2'h2

`endif

// ### common/pwc_pkg.sv
/*
 * types shared by the clock configuration block.
 * assumes: compiled before any design file.
 */
package pwc_pkg;
	// fractional generator settings for generators one and two
	typedef struct packed {
		logic [8:0] denom;
		logic [8:0] numer;
	} pwc_gen_cfg_t;

	// generator three effective ratio: out = ref * mult / div
	typedef struct packed {
		logic [15:0] mult;
		logic [15:0] div;
	} pwc_ratio_t;

	// register selector produced by the address decoder
	typedef enum logic [3:0] {
		PWC_R_NONE, PWC_R_SUP_CTRL, PWC_R_G1_DENOM, PWC_R_G1_NUMER,
		PWC_R_G2_DENOM, PWC_R_G2_NUMER, PWC_R_G3_DENOM, PWC_R_G3_NUMER,
		PWC_R_G3_SRC, PWC_R_SUP_STAT
	} pwc_reg_sel_t;

	// watchdog states, gray coded along idle -> reset -> relock
	typedef enum logic [1:0] {
		PWC_WD_IDLE = 2'h0,
		PWC_WD_RESET = 2'h1,
		PWC_WD_RELOCK = 2'h3
	} pwc_wd_state_t;
endpackage

// ### hw/pwc_clock_ctrl.sv
/*
 * pll watchdog and audio clock generator configuration, axi4-lite slave.
 * assumes: all inputs synchronous to clock; reference pins are sampled
 * on the system clock, which runs far faster than any audio frame clock.
 */
// Behaviour
// - watchdog resets unstable pll without software
// - pll relocks itself with unchanged configuration
// - watchdog enable is bit 0, resets enabled
// - generator one denominator 9 bits, resets six
// - generator one numerator 9 bits, resets one
// - generator two denominator 9 bits, resets nine
// - generator two numerator 9 bits, resets one
// - generator three denominator 16 bits, resets zero
// - generator three numerator 16 bits, resets zero
// - bit 4 picks external pin or pll
// - pll reference: multiply by denominator, divide numerator
// - external reference: times numerator over 1024
// - pin code 1110 selects spdif recovered clock
// - source register resets to pll, spdif pin
// - external reference ignores the denominator field
// - codes 0-3 multipurpose pins, 4-5 frame pins
`timescale 1ns/1ps
`include "pwc_regs.svh"

module pwc_clock_ctrl (
	input wire logic clock,
	input wire logic rst,
	// axi4-lite write address
	input wire logic [`PWC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [`PWC_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// pll supervision
	input wire logic pll_unstable,
	input wire logic pll_lock,
	output logic pll_reset,
	output logic pll_relocking,
	// reference inputs for generator three
	input wire logic [3:0] multipurpose_pin,
	input wire logic [1:0] output_frame_clock_pin,
	input wire logic spdif_rx_clock,
	// generator settings
	output pwc_pkg::pwc_gen_cfg_t gen_one_cfg,
	output pwc_pkg::pwc_gen_cfg_t gen_two_cfg,
	output pwc_pkg::pwc_ratio_t gen_three_ratio,
	output logic gen_three_ref_ext,
	output logic gen_three_ref_clock
);
	import pwc_pkg::*;

	// ------------------------------------------------------------------
	// functions
	// ------------------------------------------------------------------

	// maps a byte address onto a register; misaligned or unknown is none
	function automatic pwc_reg_sel_t decode(
		input logic [`PWC_ADDR_W-1:0] addr);
		pwc_reg_sel_t sel;
		sel = PWC_R_NONE;
		if (addr[1:0] == 2'h0) begin
			case (addr[`PWC_ADDR_W-1:2])
				`PWC_IDX_SUP_CTRL: sel = PWC_R_SUP_CTRL;
				`PWC_IDX_G1_DENOM: sel = PWC_R_G1_DENOM;
				`PWC_IDX_G1_NUMER: sel = PWC_R_G1_NUMER;
				`PWC_IDX_G2_DENOM: sel = PWC_R_G2_DENOM;
				`PWC_IDX_G2_NUMER: sel = PWC_R_G2_NUMER;
				`PWC_IDX_G3_DENOM: sel = PWC_R_G3_DENOM;
				`PWC_IDX_G3_NUMER: sel = PWC_R_G3_NUMER;
				`PWC_IDX_G3_SRC: sel = PWC_R_G3_SRC;
				`PWC_IDX_SUP_STAT: sel = PWC_R_SUP_STAT;
				default: sel = PWC_R_NONE;
			endcase
		end
		return sel;
	endfunction

	// merges the two low byte lanes of a write into a 16-bit value
	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [15:0] res;
		res = old;
		if (strb[0]) begin
			res[7:0] = data[7:0];
		end
		if (strb[1]) begin
			res[15:8] = data[15:8];
		end
		return res;
	endfunction

	// ------------------------------------------------------------------
	// registers and bus state
	// ------------------------------------------------------------------
	logic sup_en_r; // watchdog enable
	logic [8:0] g1_denom_r; // generator one denominator
	logic [8:0] g1_numer_r; // generator one numerator
	logic [8:0] g2_denom_r; // generator two denominator
	logic [8:0] g2_numer_r; // generator two numerator
	logic [15:0] g3_denom_r; // generator three denominator
	logic [15:0] g3_numer_r; // generator three numerator
	logic g3_ext_r; // generator three uses external reference
	logic [3:0] g3_pin_r; // external reference pin code
	logic [7:0] recover_cnt_r; // saturating count of pll recoveries
	logic aw_held_r; // write address latched
	logic w_held_r; // write data latched
	logic [`PWC_ADDR_W-1:0] awaddr_r; // latched write address
	logic [31:0] wdata_r; // latched write data
	logic [3:0] wstrb_r; // latched byte strobes
	logic bvalid_r; // write response pending
	logic [1:0] bresp_r; // write response code
	logic rvalid_r; // read data pending
	logic [31:0] rdata_r; // read data
	logic [1:0] rresp_r; // read response code
	logic wr_go; // both halves present, perform write
	pwc_reg_sel_t wr_sel; // register addressed by the write
	pwc_reg_sel_t rd_sel; // register addressed by the read
	logic [15:0] old_val; // current value of written register
	logic [15:0] new_val; // value after byte lanes applied
	pwc_wd_state_t wd_state_r; // watchdog state
	pwc_wd_state_t wd_state_nxt; // next watchdog state
	logic [4:0] wd_cnt_r; // reset hold counter
	logic pll_reset_r; // pll reset output
	pwc_ratio_t ratio_r; // generator three ratio
	logic ref_clk_r; // sampled reference clock

	// ------------------------------------------------------------------
	// axi4-lite write channel
	// ------------------------------------------------------------------

	// channels accepted independently, blocked while a response waits
	assign s_axi_awready = !aw_held_r && !bvalid_r;
	assign s_axi_wready = !w_held_r && !bvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign wr_go = aw_held_r && w_held_r && !bvalid_r;
	assign wr_sel = decode(awaddr_r);

	// latches address and data, raises the response after the write
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= 32'h0;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= `PWC_AXI_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_go) begin
				// writes to unknown or read-only words are refused
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= (wr_sel == PWC_R_NONE ||
					wr_sel == PWC_R_SUP_STAT) ?
					`PWC_AXI_SLVERR : `PWC_AXI_OKAY;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// current contents of the addressed register, reserved bits zero
	always_comb begin
		old_val = 16'h0;
		case (wr_sel)
			PWC_R_SUP_CTRL: old_val = {15'h0, sup_en_r};
			PWC_R_G1_DENOM: old_val = {7'h0, g1_denom_r};
			PWC_R_G1_NUMER: old_val = {7'h0, g1_numer_r};
			PWC_R_G2_DENOM: old_val = {7'h0, g2_denom_r};
			PWC_R_G2_NUMER: old_val = {7'h0, g2_numer_r};
			PWC_R_G3_DENOM: old_val = g3_denom_r;
			PWC_R_G3_NUMER: old_val = g3_numer_r;
			PWC_R_G3_SRC: old_val = {11'h0, g3_ext_r, g3_pin_r};
			default: old_val = 16'h0;
		endcase
		new_val = merge(old_val, wdata_r, wstrb_r);
	end

	// ------------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------------

	// watchdog enable; reserved bits are dropped on write
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sup_en_r <= `PWC_RST_SUP_CTRL;
		end else if (wr_go && wr_sel == PWC_R_SUP_CTRL) begin
			sup_en_r <= new_val[`PWC_SUP_EN_BIT];
		end
	end

	// generators one and two, nine-bit fields
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			g1_denom_r <= `PWC_RST_G1_DENOM;
			g1_numer_r <= `PWC_RST_G1_NUMER;
			g2_denom_r <= `PWC_RST_G2_DENOM;
			g2_numer_r <= `PWC_RST_G2_NUMER;
		end else if (wr_go) begin
			case (wr_sel)
				PWC_R_G1_DENOM: g1_denom_r <= new_val[8:0];
				PWC_R_G1_NUMER: g1_numer_r <= new_val[8:0];
				PWC_R_G2_DENOM: g2_denom_r <= new_val[8:0];
				PWC_R_G2_NUMER: g2_numer_r <= new_val[8:0];
				default: ;
			endcase
		end
	end

	// generator three fields and reference source
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			g3_denom_r <= `PWC_RST_G3_DENOM;
			g3_numer_r <= `PWC_RST_G3_NUMER;
			g3_ext_r <= `PWC_RST_G3_EXT;
			g3_pin_r <= `PWC_RST_G3_PIN;
		end else if (wr_go) begin
			case (wr_sel)
				PWC_R_G3_DENOM: g3_denom_r <= new_val;
				PWC_R_G3_NUMER: g3_numer_r <= new_val;
				PWC_R_G3_SRC: begin
					g3_ext_r <= new_val[`PWC_SRC_EXT_BIT];
					g3_pin_r <= new_val[`PWC_SRC_PIN_HI:`PWC_SRC_PIN_LO];
				end
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// axi4-lite read channel
	// ------------------------------------------------------------------
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign rd_sel = decode(s_axi_araddr);

	// one-cycle read; unknown address answers zero with slverr
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0;
			rresp_r <= `PWC_AXI_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_r <= 1'b1;
			rresp_r <= `PWC_AXI_OKAY;
			case (rd_sel)
				PWC_R_SUP_CTRL: rdata_r <= {31'h0, sup_en_r};
				PWC_R_G1_DENOM: rdata_r <= {23'h0, g1_denom_r};
				PWC_R_G1_NUMER: rdata_r <= {23'h0, g1_numer_r};
				PWC_R_G2_DENOM: rdata_r <= {23'h0, g2_denom_r};
				PWC_R_G2_NUMER: rdata_r <= {23'h0, g2_numer_r};
				PWC_R_G3_DENOM: rdata_r <= {16'h0, g3_denom_r};
				PWC_R_G3_NUMER: rdata_r <= {16'h0, g3_numer_r};
				PWC_R_G3_SRC: rdata_r <= {27'h0, g3_ext_r, g3_pin_r};
				PWC_R_SUP_STAT: rdata_r <= {16'h0, recover_cnt_r,
					4'h0, pll_lock, pll_reset_r, wd_state_r};
				default: begin
					rdata_r <= 32'h0;
					rresp_r <= `PWC_AXI_SLVERR;
				end
			endcase
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// pll watchdog
	// ------------------------------------------------------------------

	// next state: unstable pll is reset, then left to relock
	always_comb begin
		wd_state_nxt = wd_state_r;
		case (wd_state_r)
			PWC_WD_IDLE: begin
				if (sup_en_r && pll_unstable) begin
					wd_state_nxt = PWC_WD_RESET;
				end
			end
			PWC_WD_RESET: begin
				if (wd_cnt_r == 5'(`PWC_PLL_RST_CYC - 1)) begin
					wd_state_nxt = PWC_WD_RELOCK;
				end
			end
			PWC_WD_RELOCK: begin
				if (!sup_en_r) begin
					wd_state_nxt = PWC_WD_IDLE;
				end else if (pll_unstable) begin
					wd_state_nxt = PWC_WD_RESET;
				end else if (pll_lock) begin
					wd_state_nxt = PWC_WD_IDLE;
				end
			end
			default: wd_state_nxt = PWC_WD_IDLE;
		endcase
	end

	// state, hold counter and reset output; config is never touched
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wd_state_r <= PWC_WD_IDLE;
			wd_cnt_r <= 5'h0;
			pll_reset_r <= 1'b0;
		end else begin
			wd_state_r <= wd_state_nxt;
			pll_reset_r <= (wd_state_nxt == PWC_WD_RESET);
			if (wd_state_r == PWC_WD_RESET) begin
				wd_cnt_r <= wd_cnt_r + 5'h1;
			end else begin
				wd_cnt_r <= 5'h0;
			end
		end
	end

	// counts recoveries for software, saturating
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			recover_cnt_r <= 8'h0;
		end else if (wd_state_r == PWC_WD_IDLE &&
			wd_state_nxt == PWC_WD_RESET && recover_cnt_r != 8'hff) begin
			recover_cnt_r <= recover_cnt_r + 8'h1;
		end
	end

	assign pll_reset = pll_reset_r;
	assign pll_relocking = (wd_state_r == PWC_WD_RELOCK);

	// ------------------------------------------------------------------
	// generator three reference and ratio
	// ------------------------------------------------------------------

	// effective ratio; external mode ignores the denominator
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ratio_r <= '0;
		end else if (g3_ext_r) begin
			ratio_r.mult <= g3_numer_r;
			ratio_r.div <= `PWC_EXT_DIVISOR;
		end else begin
			ratio_r.mult <= g3_denom_r;
			ratio_r.div <= g3_numer_r;
		end
	end

	// pin mux; the far end supplies a 50% square wave
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ref_clk_r <= 1'b0;
		end else begin
			case (g3_pin_r)
				`PWC_PIN_MP0: ref_clk_r <= multipurpose_pin[0];
				`PWC_PIN_MP1: ref_clk_r <= multipurpose_pin[1];
				`PWC_PIN_MP2: ref_clk_r <= multipurpose_pin[2];
				`PWC_PIN_MP3: ref_clk_r <= multipurpose_pin[3];
				`PWC_PIN_FRM0: ref_clk_r <= output_frame_clock_pin[0];
				`PWC_PIN_FRM1: ref_clk_r <= output_frame_clock_pin[1];
				`PWC_PIN_SPDIF: ref_clk_r <= spdif_rx_clock;
				default: ref_clk_r <= 1'b0;
			endcase
		end
	end

	assign gen_one_cfg = '{denom: g1_denom_r, numer: g1_numer_r};
	assign gen_two_cfg = '{denom: g2_denom_r, numer: g2_numer_r};
	assign gen_three_ratio = ratio_r;
	assign gen_three_ref_ext = g3_ext_r;
	assign gen_three_ref_clock = ref_clk_r;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	a_wdog_trips_reset: assert property (
		@(posedge clock) disable iff (rst)
		(wd_state_r == PWC_WD_IDLE && sup_en_r && pll_unstable)
		|=> pll_reset)
		else $error("watchdog did not reset unstable pll");

	a_wdog_off_quiet: assert property (
		@(posedge clock) disable iff (rst)
		(wd_state_r == PWC_WD_IDLE && !sup_en_r) |=> !pll_reset)
		else $error("disabled watchdog reset the pll");

	a_reset_hold_len: assert property (
		@(posedge clock) disable iff (rst)
		$rose(pll_reset) |-> ##19 (pll_reset && pll_relocking == 1'b0)
		##1 (!pll_reset && pll_relocking))
		else $error("pll reset hold length wrong");

	a_relock_done: assert property (
		@(posedge clock) disable iff (rst)
		(pll_relocking && sup_en_r && !pll_unstable && pll_lock)
		|=> (wd_state_r == PWC_WD_IDLE && !pll_reset))
		else $error("relock did not return to idle");

	a_g3_pll_ratio: assert property (
		@(posedge clock) disable iff (rst)
		!g3_ext_r |=> (gen_three_ratio.mult == $past(g3_denom_r) &&
		gen_three_ratio.div == $past(g3_numer_r)))
		else $error("pll reference ratio wrong");

	a_g3_ext_ratio: assert property (
		@(posedge clock) disable iff (rst)
		g3_ext_r |=> (gen_three_ratio.mult == $past(g3_numer_r) &&
		gen_three_ratio.div == `PWC_EXT_DIVISOR))
		else $error("external reference ratio wrong");

	a_spdif_route: assert property (
		@(posedge clock) disable iff (rst)
		(g3_pin_r == `PWC_PIN_SPDIF) |=>
		gen_three_ref_clock == $past(spdif_rx_clock))
		else $error("spdif clock not routed");

	a_sup_write_en: assert property (
		@(posedge clock) disable iff (rst)
		(wr_go && wr_sel == PWC_R_SUP_CTRL && wstrb_r[0])
		|=> (sup_en_r == $past(wdata_r[0]) && s_axi_bvalid))
		else $error("enable write not applied");

	a_rdata_stable: assert property (@(posedge clock) disable iff (rst)
		(s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid &&
		$stable(s_axi_rdata)))
		else $error("read data dropped before taken");
endmodule

// ### bench/tb.sv
/*
 * self-checking bench for the pll supervisor and clock generator block.
 * assumes: pwc_regs.svh on the include path, pwc_pkg compiled first.
 */
`timescale 1ns/1ps
`include "pwc_regs.svh"

module tb;
import pwc_pkg::*;
// ----------------------------------------------------------------------
// signals
// ----------------------------------------------------------------------
logic clock, rst; // system clock, reset
logic [17:0] s_axi_awaddr, s_axi_araddr;
logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
logic [31:0] s_axi_wdata, s_axi_rdata; // bus data
logic [3:0] s_axi_wstrb;
logic [1:0] s_axi_bresp, s_axi_rresp;
logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
logic s_axi_rvalid, s_axi_rready;
logic pll_unstable, pll_lock, pll_reset, pll_relocking; // supervision
logic [3:0] multipurpose_pin; // reference pins
logic [1:0] output_frame_clock_pin;
logic spdif_rx_clock, gen_three_ref_ext, gen_three_ref_clock;
pwc_gen_cfg_t gen_one_cfg, gen_two_cfg;
pwc_ratio_t gen_three_ratio;
int n_fail, n_tests; // mismatch and comparison counts
logic [1:0] rsp; // last bus response
logic [31:0] rd; // last read data
int hi; // cycles with pll reset high
logic [15:0] ix[8] = '{`PWC_IDX_SUP_CTRL, `PWC_IDX_G1_DENOM,
	`PWC_IDX_G1_NUMER, `PWC_IDX_G2_DENOM, `PWC_IDX_G2_NUMER,
	`PWC_IDX_G3_DENOM, `PWC_IDX_G3_NUMER, `PWC_IDX_G3_SRC};
logic [15:0] rv[8] = '{16'h0001, 16'h0006, 16'h0001, 16'h0009,
	16'h0001, 16'h0000, 16'h0000, 16'h000e}; // reset values
logic [15:0] mk[8] = '{16'h0001, 16'h01ff, 16'h01ff, 16'h01ff,
	16'h01ff, 16'hffff, 16'hffff, 16'h001f}; // writable bits
logic [3:0] codes[8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'he, 4'h7};

pwc_clock_ctrl DUT (.clock(clock), .rst(rst),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
	.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .pll_unstable(pll_unstable),
	.pll_lock(pll_lock), .pll_reset(pll_reset),
	.pll_relocking(pll_relocking), .multipurpose_pin(multipurpose_pin),
	.output_frame_clock_pin(output_frame_clock_pin),
	.spdif_rx_clock(spdif_rx_clock), .gen_one_cfg(gen_one_cfg),
	.gen_two_cfg(gen_two_cfg), .gen_three_ratio(gen_three_ratio),
	.gen_three_ref_ext(gen_three_ref_ext),
	.gen_three_ref_clock(gen_three_ref_clock));

// ----------------------------------------------------------------------
// clock, watchdog, closing
// ----------------------------------------------------------------------
// 50 ns period
initial begin
	clock = 1'b0;
	forever #25 clock = ~clock;
end

// cuts a hang short; the tests need well under 2000 cycles
initial begin
	#(50 * 4000);
	n_fail++;
	give_verdict();
end

task automatic give_verdict();
	$display("comparisons %0d, mismatches %0d", n_tests, n_fail);
	if (n_fail == 0 && n_tests > 0) begin
		$display("bench passed");
	end else begin
		$display("bench failed");
	end
	$finish;
endtask

// compare one value, report a mismatch at once
task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
	n_tests++;
	if (g !== e) begin
		$display("unexpected %s: expected %h, seen %h", nm, e, g);
		n_fail++;
	end
endtask

// ----------------------------------------------------------------------
// bus tasks: handshakes judged at the falling edge, acted on at rising
// ----------------------------------------------------------------------
task automatic axi_wr(input logic [15:0] idx, input logic [31:0] d);
	logic a, w, b;
	int k;
	b = 1'b0;
	k = 0;
	@(posedge clock);
	s_axi_awaddr <= {idx, 2'h0};
	s_axi_wdata <= d;
	s_axi_awvalid <= 1'b1;
	s_axi_wvalid <= 1'b1;
	s_axi_bready <= 1'b1;
	while (!b && k < 100) begin
		@(negedge clock);
		a = s_axi_awvalid && s_axi_awready;
		w = s_axi_wvalid && s_axi_wready;
		b = s_axi_bvalid;
		rsp = s_axi_bresp;
		@(posedge clock);
		if (a) s_axi_awvalid <= 1'b0;
		if (w) s_axi_wvalid <= 1'b0;
		if (b) s_axi_bready <= 1'b0;
		k++;
	end
	chk("write answer", 1, b);
endtask

task automatic axi_rd(input logic [15:0] idx);
	logic a, r;
	int k;
	r = 1'b0;
	k = 0;
	@(posedge clock);
	s_axi_araddr <= {idx, 2'h0};
	s_axi_arvalid <= 1'b1;
	s_axi_rready <= 1'b1;
	while (!r && k < 100) begin
		@(negedge clock);
		a = s_axi_arvalid && s_axi_arready;
		r = s_axi_rvalid;
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		@(posedge clock);
		if (a) s_axi_arvalid <= 1'b0;
		if (r) s_axi_rready <= 1'b0;
		k++;
	end
	chk("read answer", 1, r);
endtask

// one unstable pulse, then count reset-high cycles over 30 cycles
task automatic wd_pulse();
	@(posedge clock);
	pll_unstable <= 1'b1;
	@(posedge clock);
	pll_unstable <= 1'b0;
	hi = 0;
	repeat (30) begin
		@(negedge clock);
		hi += pll_reset;
	end
endtask

// ----------------------------------------------------------------------
// tests
// ----------------------------------------------------------------------
initial begin
	{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
	{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
	{s_axi_arvalid, s_axi_rready, pll_unstable, pll_lock} = '0;
	s_axi_wstrb = 4'hf;
	{spdif_rx_clock, output_frame_clock_pin, multipurpose_pin} = '0;
	n_fail = 0;
	n_tests = 0;
	rst = 1'b1;
	repeat (10) @(posedge clock);
	rst <= 1'b0;
	// reset values at the writable registers and generator one and two outputs
	for (int i = 0; i < 8; i++) begin
		axi_rd(ix[i]);
		chk("reset value", {16'h0, rv[i]}, rd);
	end
	chk("gen one reset", {9'h006, 9'h001}, gen_one_cfg);
	chk("gen two reset", {9'h009, 9'h001}, gen_two_cfg);
	$display("test reset values done");
	// all ones written: only fields stick, reserved bits read zero
	for (int i = 0; i < 8; i++) begin
		axi_wr(ix[i], 32'hffffffff);
		chk("write resp", `PWC_AXI_OKAY, rsp);
		axi_rd(ix[i]);
		chk("masked readback", {16'h0, mk[i]}, rd);
	end
	chk("gen one cfg", {9'h1ff, 9'h1ff}, gen_one_cfg);
	chk("gen two cfg", {9'h1ff, 9'h1ff}, gen_two_cfg);
	axi_rd(16'hf010);
	chk("unmapped read resp", `PWC_AXI_SLVERR, rsp);
	chk("unmapped read data", 0, rd);
	$display("test register access done");
	// generator three ratio for both references
	axi_wr(`PWC_IDX_G3_DENOM, 32'h00001234);
	axi_wr(`PWC_IDX_G3_NUMER, 32'h00000567);
	axi_wr(`PWC_IDX_G3_SRC, 32'h0000ffee); // reserved bits set
	repeat (2) @(posedge clock);
	chk("pll ratio", {16'h1234, 16'h0567}, gen_three_ratio);
	chk("ref ext clear", 0, gen_three_ref_ext);
	axi_wr(`PWC_IDX_G3_SRC, 32'h0000001e);
	repeat (2) @(posedge clock);
	chk("ext ratio", {16'h0567, 16'h0400}, gen_three_ratio);
	chk("ref ext set", 1, gen_three_ref_ext);
	axi_wr(`PWC_IDX_G3_DENOM, 32'h0000beef);
	repeat (2) @(posedge clock);
	chk("denom ignored", {16'h0567, 16'h0400}, gen_three_ratio);
	// high byte lane only: low byte keeps its old value
	s_axi_wstrb <= 4'h2;
	axi_wr(`PWC_IDX_G3_NUMER, 32'h0000abcd);
	s_axi_wstrb <= 4'hf;
	axi_rd(`PWC_IDX_G3_NUMER);
	chk("byte lane", 32'h0000ab67, rd);
	$display("test generator three ratio done");
	// each pin code: target pin alone high, then alone low; unmapped code 7 with all pins high in both phases
	foreach (codes[i]) begin
		int s;
		logic ok;
		ok = codes[i] < 4'h6 || codes[i] == 4'he;
		s = codes[i] == 4'he ? 6 : int'(codes[i]);
		axi_wr(`PWC_IDX_G3_SRC, {27'h0, 1'b1, codes[i]});
		{spdif_rx_clock, output_frame_clock_pin, multipurpose_pin} <=
			ok ? 7'h1 << s : 7'h7f;
		repeat (3) @(posedge clock);
		chk("ref pin high", ok, gen_three_ref_clock);
		{spdif_rx_clock, output_frame_clock_pin, multipurpose_pin} <=
			~(7'h1 << s);
		repeat (3) @(posedge clock);
		chk("ref pin low", 0, gen_three_ref_clock);
	end
	// spdif reference as a 50% square wave, followed one cycle later
	axi_wr(`PWC_IDX_G3_SRC, 32'h0000001e);
	repeat (4) begin
		spdif_rx_clock <= ~spdif_rx_clock;
		repeat (4) @(posedge clock);
		chk("ref follows", spdif_rx_clock, gen_three_ref_clock);
	end
	$display("test reference pins done");
	// watchdog recovery with configuration kept
	axi_wr(`PWC_IDX_G1_DENOM, 32'h00000123);
	wd_pulse();
	chk("reset cycles", 20, hi);
	chk("relocking", 1, pll_relocking);
	chk("cfg kept", {9'h123, 9'h1ff}, gen_one_cfg);
	@(posedge clock);
	pll_lock <= 1'b1;
	repeat (2) @(posedge clock);
	chk("relock done", 0, pll_relocking);
	pll_lock <= 1'b0;
	// supervision disabled ignores instability
	axi_wr(`PWC_IDX_SUP_CTRL, 32'hfffffffe);
	wd_pulse();
	chk("disabled", 0, hi);
	axi_wr(`PWC_IDX_SUP_CTRL, 32'h00000001);
	wd_pulse();
	chk("re-enabled", 20, hi);
	// two recoveries counted, now waiting for relock, reset low
	axi_rd(`PWC_IDX_SUP_STAT);
	chk("status word", 32'h00000203, rd);
	axi_wr(`PWC_IDX_SUP_STAT, 32'h00000000);
	chk("status write resp", `PWC_AXI_SLVERR, rsp);
	$display("test watchdog done");
	give_verdict();
end
endmodule
